// [verilog/dma_seq_pkg.sv]
// shared constants for the dual dma bus master sequencer
// assumes a 200 mhz clock and an avalon-mm register master
package dma_seq_pkg;
    // register byte offsets
    localparam logic [5:0] CTRL_OFS      = 6'h00;
    localparam logic [5:0] CONFIG_OFS    = 6'h04;
    localparam logic [5:0] RADDR_LO_OFS  = 6'h08;
    localparam logic [5:0] RADDR_HI_OFS  = 6'h0c;
    localparam logic [5:0] RCOUNT_OFS    = 6'h10;
    localparam logic [5:0] LADDR_OFS     = 6'h14;
    localparam logic [5:0] STATUS_OFS    = 6'h18;
    // control bits (stop and start act on a one; remote read bit takes the written value, remote write bit takes it only when read is clear)
    localparam int CTRL_STOP_BIT    = 0;
    localparam int CTRL_START_BIT   = 1;
    localparam int CTRL_RREAD_BIT   = 2;
    localparam int CTRL_RWRITE_BIT  = 3;
    // data_configuration_setting fields
    localparam int CFG_WORD_BIT     = 0;
    localparam int CFG_LONG_BIT     = 2;
    localparam int CFG_BURST_LSB    = 5;
    localparam int CFG_THRESH_LSB   = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // last phase of the four-clock bus cycle
    localparam logic [1:0] CYCLE_LAST = 2'h3;
    // bus states
    typedef enum logic [5:0] {
        ST_RESET = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_REQ   = 6'b000100,
        ST_UPPER = 6'b001000,
        ST_XFER  = 6'b010000,
        ST_GAP   = 6'b100000
    } bus_state_type;
endpackage : dma_seq_pkg

// [verilog/dual_dma_bus_master_sequencer.sv]
// bus master sequencer for the local (fifo) and remote (port) dma channels
// assumes bus grant, fifo flags and port strobes arrive asynchronously
// Summary of operation
// - roles are master, slave, or idle
// - reset enters reset state, rx/tx disabled
// - stop, reset or fifo error re-enter reset
// - start command moves to idle
// - service request, grant handshake, transfer, idle
// - 16/32-bit address with 8/16-bit data
// - each bus cycle lasts four clocks
// - 32-bit mode adds upper-address cycle per burst
// - local burst moves exact length then releases
// - burst 1,2,4,6 words or 2,4,8,12 bytes
// - next burst waits for threshold again
// - grant withdrawn mid-burst aborts burst
// - local outranks remote; remote resumes after
// - fifo need during remote keeps request
// - local to remote drops request once
// - remote arbitrates per byte or word
// - port moves one direction at a time
// - remote read: fetch, count, request, ack
// - remote write: request, host writes, store
// - drop request after each remote item
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module dual_dma_bus_master_sequencer
    import dma_seq_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // avalon-mm register slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // local bus arbitration
    output logic             bus_request_out,
    input  wire logic        bus_grant_in,
    // local memory bus
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic [15:0] mem_rdata,
    output logic             mem_addr_oe,
    output logic             mem_rd,
    output logic             mem_wr,
    // fifo side
    input  wire logic        fifo_rx_need,
    input  wire logic        fifo_tx_need,
    input  wire logic        fifo_error,
    output logic             fifo_strobe,
    // host port
    output logic             port_service_request,
    input  wire logic        port_read_acknowledge,
    input  wire logic        port_write_strobe,
    input  wire logic [15:0] port_wdata,
    output logic [15:0]      port_rdata,
    // status pins
    output logic             rx_enable,
    output logic             tx_enable,
    output logic             bus_master
);
    import dma_seq_pkg::*;

    // burst length in bus cycles, from config
    function automatic logic [3:0] burst_cycles(input logic [7:0] cfg);
        logic [3:0] n;
        n = 4'h1;
        case (cfg[CFG_BURST_LSB +: 2])
            2'h0: n = 4'h1;
            2'h1: n = 4'h2;
            2'h2: n = 4'h4;
            default: n = 4'h6;
        endcase
        // byte mode doubles item count: 2,4,8,12 bytes
        burst_cycles = cfg[CFG_WORD_BIT] ? n : 4'((n << 1));
    endfunction : burst_cycles

    logic       rst_meta_r, rst_sync_r;
    logic       rst_n;
    bus_state_type state_r;
    logic [3:0] sync1_r, sync2_r;
    logic       gnt_s, rxn_s, txn_s, err_s;
    logic [1:0] port_read_acknowledge_m_r, port_read_acknowledge_s_r, iow_m_r, iow_s_r;
    logic       port_read_acknowledge_rise, iow_rise;
    logic [7:0] cfg_r;
    logic [15:0] raddr_r, rhi_r, rcount_r, laddr_r;
    logic       rd_done_r, rread_r, rwrite_r;
    logic       latch_full_r, is_local_r;
    logic [1:0] phase_r;
    logic [3:0] beats_r;
    logic       fifo_need, remote_need, rem_active, local_armed_r;
    logic [15:0] step;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    assign rst_n = rst_sync_r;

    // two-flop synchronisers; grant sampled on clock
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            sync1_r  <= 4'h0;
            sync2_r  <= 4'h0;
            port_read_acknowledge_m_r <= 2'h0;
            port_read_acknowledge_s_r <= 2'h0;
            iow_m_r  <= 2'h0;
            iow_s_r  <= 2'h0;
        end
        else
        begin
            sync1_r  <= {bus_grant_in, fifo_rx_need, fifo_tx_need, fifo_error};
            sync2_r  <= sync1_r;
            port_read_acknowledge_m_r <= {port_read_acknowledge_m_r[0], port_read_acknowledge};
            port_read_acknowledge_s_r <= {port_read_acknowledge_s_r[0], port_read_acknowledge_m_r[1]};
            iow_m_r  <= {iow_m_r[0], port_write_strobe};
            iow_s_r  <= {iow_s_r[0], iow_m_r[1]};
        end
    assign {gnt_s, rxn_s, txn_s, err_s} = sync2_r;
    // host strobes asynchronous; edges taken after sync
    assign port_read_acknowledge_rise = port_read_acknowledge_s_r[1] & ~port_read_acknowledge_s_r[0];
    assign iow_rise  = iow_s_r[1] & ~iow_s_r[0];

    // local need gated so burst leftovers wait for threshold
    assign fifo_need   = (rxn_s | txn_s) & local_armed_r;
    assign rem_active  = rread_r | rwrite_r;
    // remote read needs empty latch, write needs full latch
    assign remote_need = (rread_r & ~latch_full_r & (rcount_r != 16'h0000))
                       | (rwrite_r & latch_full_r);
    assign step = cfg_r[CFG_WORD_BIT] ? 16'h0002 : 16'h0001;

    // register slave: one wait state so registered read data stands
    assign avs_waitrequest = avs_read & ~rd_done_r;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            rd_done_r <= 1'b0;
        else
            rd_done_r <= avs_read & ~rd_done_r;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read)
            case (avs_address)
                CTRL_OFS:     avs_readdata <= {30'h0, rwrite_r, rread_r};
                CONFIG_OFS:   avs_readdata <= {24'h0, cfg_r};
                RADDR_LO_OFS: avs_readdata <= {16'h0, raddr_r};
                RADDR_HI_OFS: avs_readdata <= {16'h0, rhi_r};
                RCOUNT_OFS:   avs_readdata <= {16'h0, rcount_r};
                LADDR_OFS:    avs_readdata <= {16'h0, laddr_r};
                STATUS_OFS:   avs_readdata <= {26'h0, state_r};
                default:      avs_readdata <= 32'h0000_0000;
            endcase

    // bus state machine
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            state_r <= ST_RESET;
        else if ((avs_write && avs_address == CTRL_OFS
                  && avs_writedata[CTRL_STOP_BIT]) || err_s)
            state_r <= ST_RESET;
        else
            case (state_r)
                ST_RESET:
                    if (avs_write && avs_address == CTRL_OFS
                        && avs_writedata[CTRL_START_BIT])
                        state_r <= ST_IDLE;
                ST_IDLE:
                    if (fifo_need || remote_need)
                        state_r <= ST_REQ;
                ST_REQ:
                    if (gnt_s)
                        state_r <= cfg_r[CFG_LONG_BIT] ? ST_UPPER : ST_XFER;
                ST_UPPER:
                    if (!gnt_s)
                        state_r <= ST_IDLE;
                    else if (phase_r == CYCLE_LAST)
                        state_r <= ST_XFER;
                ST_XFER:
                    if (!gnt_s)
                        state_r <= ST_IDLE;
                    else if (phase_r == CYCLE_LAST)
                    begin
                        if (is_local_r && beats_r != 4'h1)
                            state_r <= ST_XFER;
                        // remote item done; fifo joins while bus held
                        else if (!is_local_r && fifo_need)
                            state_r <= cfg_r[CFG_LONG_BIT] ? ST_UPPER
                                                           : ST_XFER;
                        else if (is_local_r && remote_need)
                            state_r <= ST_GAP;
                        else
                            state_r <= ST_IDLE;
                    end
                ST_GAP:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_RESET;
            endcase

    // four-clock bus cycle phase counter
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            phase_r <= 2'h0;
        else if (state_r == ST_UPPER || state_r == ST_XFER)
            phase_r <= 2'(phase_r + 2'h1);
        else
            phase_r <= 2'h0;

    // channel choice: local outranks remote
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            is_local_r  <= 1'b0;
            beats_r     <= 4'h0;
        end
        else if ((state_r == ST_IDLE && (fifo_need || remote_need))
                 || (state_r == ST_XFER && phase_r == CYCLE_LAST
                     && !is_local_r && fifo_need))
        begin
            is_local_r  <= fifo_need;
            beats_r     <= burst_cycles(cfg_r);
        end
        else if (state_r == ST_XFER && phase_r == CYCLE_LAST && is_local_r)
            beats_r <= 4'(beats_r - 4'h1);

    // threshold rearm: fifo must drop its need after a burst
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            local_armed_r <= 1'b1;
        else if (state_r == ST_XFER && phase_r == CYCLE_LAST
                 && is_local_r && beats_r == 4'h1)
            local_armed_r <= 1'b0;
        else if (!rxn_s && !txn_s)
            local_armed_r <= 1'b1;

    // configuration and remote registers, plus the remote engine
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            cfg_r    <= CFG_RESET;
            raddr_r  <= 16'h0000;
            rhi_r    <= 16'h0000;
            rcount_r <= 16'h0000;
            laddr_r  <= 16'h0000;
            rread_r  <= 1'b0;
            rwrite_r <= 1'b0;
        end
        else
        begin
            if (avs_write)
                case (avs_address)
                    CONFIG_OFS:   cfg_r    <= avs_writedata[7:0];
                    RADDR_LO_OFS: raddr_r  <= avs_writedata[15:0];
                    RADDR_HI_OFS: rhi_r    <= avs_writedata[15:0];
                    RCOUNT_OFS:   rcount_r <= avs_writedata[15:0];
                    LADDR_OFS:    laddr_r  <= avs_writedata[15:0];
                    CTRL_OFS:
                    begin
                        // only one direction may run
                        rread_r  <= avs_writedata[CTRL_RREAD_BIT];
                        rwrite_r <= avs_writedata[CTRL_RWRITE_BIT]
                                    & ~avs_writedata[CTRL_RREAD_BIT];
                    end
                    default: ;
                endcase
            else if (state_r == ST_XFER && phase_r == CYCLE_LAST && gnt_s)
            begin
                if (is_local_r)
                    laddr_r <= 16'(laddr_r + step);
                else
                begin
                    raddr_r  <= 16'(raddr_r + step);
                    rcount_r <= (rcount_r > step) ? 16'(rcount_r - step)
                                                  : 16'h0000;
                    if (rcount_r <= step)
                        rwrite_r <= 1'b0;
                end
            end
            // read ends once the host has taken the last item
            else if (rread_r && rcount_r == 16'h0000 && !latch_full_r)
                rread_r <= 1'b0;
        end

    // port latch: read fills from memory, write fills from host
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            latch_full_r <= 1'b0;
            port_rdata   <= 16'h0000;
        end
        else if (!rem_active)
            latch_full_r <= 1'b0;
        else if (state_r == ST_XFER && phase_r == CYCLE_LAST && gnt_s
                 && !is_local_r)
        begin
            latch_full_r <= rread_r;
            if (rread_r)
                port_rdata <= mem_rdata;
        end
        else if ((rread_r && port_read_acknowledge_rise) || (rwrite_r && iow_rise))
            latch_full_r <= rwrite_r;

    // host write data captured once strobe edge is synchronised
    logic [15:0] port_hold_r;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            port_hold_r <= 16'h0000;
        else if (rwrite_r && iow_rise)
            port_hold_r <= port_wdata;

    // bus outputs, registered; request drops in gap, and in idle without a need
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            bus_request_out      <= 1'b0;
            mem_addr_oe          <= 1'b0;
            mem_addr             <= 16'h0000;
            mem_wdata            <= 16'h0000;
            mem_rd               <= 1'b0;
            mem_wr               <= 1'b0;
            fifo_strobe          <= 1'b0;
            port_service_request <= 1'b0;
        end
        else
        begin
            bus_request_out <= (state_r == ST_IDLE && (fifo_need || remote_need))
                             || state_r == ST_REQ
                             || ((state_r == ST_UPPER || state_r == ST_XFER)
                                 && gnt_s);
            mem_addr_oe <= (state_r == ST_UPPER || state_r == ST_XFER)
                           && gnt_s;
            mem_addr    <= (state_r == ST_UPPER) ? rhi_r
                         : (is_local_r ? laddr_r : raddr_r);
            mem_wdata   <= port_hold_r;
            mem_rd      <= state_r == ST_XFER && gnt_s && phase_r == 2'h1
                           && (is_local_r ? txn_s : rread_r); // tx fifo fill
            mem_wr      <= state_r == ST_XFER && gnt_s && phase_r == 2'h1
                           && !is_local_r && rwrite_r;
            fifo_strobe <= state_r == ST_XFER && gnt_s
                           && phase_r == CYCLE_LAST && is_local_r;
            // request only when latch awaits host
            port_service_request <= (rread_r & latch_full_r)
                                  | (rwrite_r & ~latch_full_r);
        end

    // role and enable pins
    assign bus_master = mem_addr_oe;
    assign rx_enable  = state_r != ST_RESET;
    assign tx_enable  = state_r != ST_RESET;
endmodule : dual_dma_bus_master_sequencer
`default_nettype wire

// [verification/dma_seq_props.sv]
// port checker for the dual dma bus master sequencer
// assumes it is bound onto every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module dma_seq_props (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // bus side
    input wire logic bus_request_out,
    input wire logic bus_grant_in,
    input wire logic mem_addr_oe,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic bus_master,
    // fifo and port side
    input wire logic fifo_error,
    input wire logic fifo_strobe,
    input wire logic port_service_request,
    input wire logic port_read_acknowledge,
    input wire logic port_write_strobe,
    input wire logic rx_enable,
    input wire logic tx_enable
);
    // one clock domain, the async reset gates every check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    AST_ROLE: assert property (bus_master == mem_addr_oe)
        else $error("master flag differs from bus drive");
    AST_RST_QUIET: assert property (!rx_enable |-> !tx_enable
        && !bus_request_out && !port_service_request)
        else $error("activity while in reset state");
    AST_ERR_RESET: assert property (fifo_error |-> ##[1:6] !rx_enable)
        else $error("fifo error did not reach reset state");
    AST_OE_REQ: assert property (mem_addr_oe |-> bus_request_out)
        else $error("bus driven without request");
    AST_CYCLE4: assert property (fifo_strobe |=> !fifo_strobe [*3])
        else $error("bus cycles shorter than four clocks");
    AST_OE_HOLD: assert property ($rose(mem_addr_oe) |-> mem_addr_oe [*4])
        else $error("tenure shorter than one bus cycle");
    AST_GRANT_LOSS: assert property (
        mem_addr_oe && !bus_grant_in |-> ##[1:6] !mem_addr_oe)
        else $error("burst kept after grant loss");
    AST_STROBE_BUS: assert property ((mem_rd || mem_wr || fifo_strobe)
        |-> mem_addr_oe && !(mem_rd && mem_wr))
        else $error("strobe outside tenure or both directions");
    AST_GRANT_SEEN: assert property ($rose(mem_addr_oe)
        |-> $past(bus_grant_in, 2))
        else $error("bus driven before grant seen");
    AST_ACK_DROP: assert property ($fell(port_read_acknowledge)
        |-> ##[0:8] !port_service_request)
        else $error("port request kept after read ack");
    AST_WSTB_DROP: assert property ($fell(port_write_strobe)
        |-> ##[0:8] !port_service_request)
        else $error("port request kept after host write");
endmodule : dma_seq_props
bind dual_dma_bus_master_sequencer dma_seq_props u_dma_seq_props (
    .clk, .arst_n, .bus_request_out, .bus_grant_in, .mem_addr_oe, .mem_rd,
    .mem_wr, .bus_master, .fifo_error, .fifo_strobe, .port_service_request,
    .port_read_acknowledge, .port_write_strobe, .rx_enable, .tx_enable);
`default_nettype wire

// [verification/mem_bus_model.sv]
// buffer memory and bus arbiter partner of the sequencer
// assumes the sequencer clock; grants late by a random wait
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model (
    // clock and command
    input  wire logic        clk,
    input  wire logic        drop_grant,
    // arbitration
    input  wire logic        bus_request_out,
    output logic             bus_grant_in,
    // memory bus
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_addr_oe,
    input  wire logic        mem_wr,
    output logic [15:0]      mem_rdata,
    // store record
    output int               wr_count = 0,
    output logic [15:0]      last_waddr = 16'h0000,
    output logic [15:0]      last_wdata = 16'h0000
);
    int          wait_cnt = 0;
    logic [15:0] junk = 16'h0000;
    // grant after a random wait; withdrawn early only on command
    always @(posedge clk)
    begin
        if (!bus_request_out || drop_grant)
        begin
            bus_grant_in <= 1'b0;
            wait_cnt <= $urandom_range(3);
        end
        else if (wait_cnt == 0)
            bus_grant_in <= 1'b1;
        else
            wait_cnt <= wait_cnt - 1;
    end
    // released bus flips every cycle so stale data never matches
    always @(posedge clk)
        junk <= ~junk ^ 16'h0101;
    assign mem_rdata = mem_addr_oe ? (mem_addr ^ 16'h5a3c) : junk;
    // record each store
    always @(posedge clk)
    begin
        if (mem_wr === 1'b1)
        begin
            wr_count <= wr_count + 1;
            last_waddr <= mem_addr;
            last_wdata <= mem_wdata;
        end
    end
endmodule : mem_bus_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the dual dma bus master sequencer
// assumes the memory partner model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dma_seq_pkg::*;
    logic clk, arst_n, avs_read, avs_write, fifo_rx_need, fifo_tx_need;
    logic fifo_error, port_read_acknowledge, port_write_strobe, drop_grant;
    logic bus_request_out, bus_grant_in, mem_addr_oe, mem_rd, mem_wr;
    logic fifo_strobe, port_service_request, rx_enable, tx_enable;
    logic bus_master, avs_waitrequest, mon_on = 1'b1;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [15:0] port_wdata, port_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] last_waddr, last_wdata, hi, ra, first_a;
    logic [32:0] exq[$], e;
    int error_cnt = 0, cmp_count = 0, oe_cyc = 0, st_cnt = 0, n, wr_count;
    dual_dma_bus_master_sequencer u_dual_dma_bus_master_sequencer (
        .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .bus_request_out, .bus_grant_in,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_addr_oe, .mem_rd, .mem_wr,
        .fifo_rx_need, .fifo_tx_need, .fifo_error, .fifo_strobe,
        .port_service_request, .port_read_acknowledge, .port_write_strobe,
        .port_wdata, .port_rdata, .rx_enable, .tx_enable, .bus_master);
    mem_bus_model u_mem_bus_model (.clk, .drop_grant, .bus_request_out,
        .bus_grant_in, .mem_addr, .mem_wdata, .mem_addr_oe, .mem_wr,
        .mem_rdata, .wr_count, .last_waddr, .last_wdata);
    // 200 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic end_sim();
        $display("mismatches %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one clock of a bounded wait
    task automatic step(inout int k);
        @(posedge clk);
        k++;
        if (k > 600)
        begin
            error_cnt++;
            $display("unexpected at %0t: wait ran out", $time);
            end_sim();
        end
    endtask : step
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do step(k); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    // read held until waitrequest low; data taken at that edge
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        int k;
        k = 0;
        avs_address <= a;
        avs_read <= 1'b1;
        do step(k); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : rd
    // one local burst; need stays up after it to prove no rerun
    task automatic burst(input logic [7:0] cfg, input bit rx);
        int k, items;
        k = 0;
        items = cfg[0] ? (cfg[6:5] == 0 ? 1 : 2 * cfg[6:5])
                       : (cfg[6:5] == 0 ? 2 : 4 * cfg[6:5]);
        wr(CONFIG_OFS, {24'h0, cfg});
        exq.push_back({cfg[2], cfg[2] ? hi : 16'h0,
                       8'(4 * (items + cfg[2])), 8'(items)});
        if (rx) fifo_rx_need <= 1'b1;
        else fifo_tx_need <= 1'b1;
        while (mem_addr_oe !== 1'b1) step(k);
        while (mem_addr_oe !== 1'b0) step(k);
        repeat (20) @(posedge clk);
        fifo_rx_need <= 1'b0;
        fifo_tx_need <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : burst
    // tenure monitor: drive cycles, fifo strobes, first address
    always @(posedge clk)
    begin
        if (mem_addr_oe === 1'b1)
        begin
            if (oe_cyc == 0) first_a = mem_addr;
            oe_cyc++;
            st_cnt += int'(fifo_strobe === 1'b1);
        end
        else if (oe_cyc != 0)
        begin
            if (mon_on && exq.size() == 0) chk(1, 0);
            else if (mon_on)
            begin
                e = exq.pop_front();
                chk({e[32], e[32] ? first_a : 16'h0, 8'(oe_cyc),
                     8'(st_cnt)}, e);
            end
            oe_cyc = 0;
            st_cnt = 0;
        end
    end
    // main sequence
    initial
    begin
        {arst_n, avs_read, avs_write, fifo_rx_need, fifo_tx_need, fifo_error,
         port_read_acknowledge, port_write_strobe, drop_grant} = '0;
        {avs_address, avs_writedata, port_wdata} = '0;
        void'($urandom(32'h5c5f9665));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(STATUS_OFS, d);
        chk(d, ST_RESET);
        chk(tx_enable, 1'b0);
        hi = 16'($urandom);
        wr(RADDR_HI_OFS, {16'h0, hi});
        wr(CTRL_OFS, 32'h1 << CTRL_START_BIT);
        rd(STATUS_OFS, d);
        chk(d, ST_IDLE);
        chk(rx_enable, 1'b1);
        rd(6'h3c, d);
        chk(d, 32'h0);
        // every burst code in both widths and both address modes
        for (int i = 0; i < 16; i++)
            burst(8'(i % 4) << 5 | 8'(i / 4 % 2) << 2 | 8'(i / 8)
                  | 8'($urandom_range(3)) << 3, i[0]);
        // grant withdrawn in the middle of a six word burst
        mon_on = 1'b0;
        wr(CONFIG_OFS, 32'h61);
        fifo_tx_need <= 1'b1;
        n = 0;
        while (mem_addr_oe !== 1'b1) step(n);
        repeat (6) @(posedge clk);
        drop_grant <= 1'b1;
        fifo_tx_need <= 1'b0;
        n = 0;
        while (mem_addr_oe !== 1'b0) step(n);
        chk(n < 8, 1'b1);
        while (bus_request_out !== 1'b0) step(n);
        drop_grant <= 1'b0;
        rd(STATUS_OFS, d);
        chk(d, ST_IDLE);
        mon_on = 1'b1;
        // remote read of three bytes, one tenure each
        wr(CONFIG_OFS, 32'h0);
        ra = 16'($urandom);
        wr(RADDR_LO_OFS, {16'h0, ra});
        wr(RCOUNT_OFS, 32'h3);
        repeat (3) exq.push_back({17'h0, 8'h04, 8'h00});
        wr(CTRL_OFS, 32'h1 << CTRL_RREAD_BIT);
        for (int i = 0; i < 3; i++)
        begin
            while (port_service_request !== 1'b1) step(n);
            chk(port_rdata[7:0], 8'(ra + i) ^ 8'h3c);
            port_read_acknowledge <= 1'b1;
            repeat (3) @(posedge clk);
            port_read_acknowledge <= 1'b0;
            while (port_service_request !== 1'b0) step(n);
        end
        repeat (20) @(posedge clk);
        chk(port_service_request, 1'b0);
        rd(STATUS_OFS, d);
        chk(d, ST_IDLE);
        // remote write of two bytes
        ra = 16'($urandom);
        wr(RADDR_LO_OFS, {16'h0, ra});
        wr(RCOUNT_OFS, 32'h2);
        repeat (2) exq.push_back({17'h0, 8'h04, 8'h00});
        wr(CTRL_OFS, 32'h1 << CTRL_RWRITE_BIT);
        for (int i = 0; i < 2; i++)
        begin
            while (port_service_request !== 1'b1) step(n);
            d = $urandom;
            port_wdata <= d[15:0];
            port_write_strobe <= 1'b1;
            repeat (3) @(posedge clk);
            port_write_strobe <= 1'b0;
            while (wr_count != i + 1) step(n);
            chk(last_waddr, 16'(ra + i));
            chk(last_wdata[7:0], d[7:0]);
        end
        repeat (20) @(posedge clk);
        chk(exq.size(), 0);
        // stop, fifo error and a second hard reset all re-enter reset
        wr(CTRL_OFS, 32'h1 << CTRL_STOP_BIT);
        rd(STATUS_OFS, d);
        chk(d, ST_RESET);
        wr(CTRL_OFS, 32'h1 << CTRL_START_BIT);
        fifo_error <= 1'b1;
        repeat (4) @(posedge clk);
        fifo_error <= 1'b0;
        rd(STATUS_OFS, d);
        chk(d, ST_RESET);
        wr(CTRL_OFS, 32'h1 << CTRL_START_BIT);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(STATUS_OFS, d);
        chk(d, ST_RESET);
        end_sim();
    end
endmodule : tb
`default_nettype wire
